//--- rtl/dmhr_pkg.sv
package dmhr_pkg;

    // One register word as seen on the serial control bus.
    typedef logic [15:0] dmhr_word_t;

    // Register addresses carried in the address byte of a frame.
    localparam logic [7:0] DMHR_ADDR_STATUS = 8'hC6;
    localparam logic [7:0] DMHR_ADDR_MODEM_CFG = 8'hC7;
    localparam logic [7:0] DMHR_ADDR_PROGRAM = 8'hC8;
    localparam logic [7:0] DMHR_ADDR_TX_DATA = 8'hCA;
    localparam logic [7:0] DMHR_ADDR_TONE_STATUS = 8'hCC;
    localparam logic [7:0] DMHR_ADDR_AUDIO = 8'hCD;

    // Bit positions in the event status word.
    localparam int ST_IRQ = 15;
    localparam int ST_WEATHER = 14;
    localparam int ST_TONE = 12;
    localparam int ST_END = 7;
    localparam int ST_RDY = 6;
    localparam int ST_SELCALL = 3;
    localparam int ST_PRG = 0;
    // Bits from two upward are cleared by a status read.
    localparam logic [15:0] ST_READ_CLEAR = 16'hFFFC;

    // Bit positions in the modem configuration word.
    localparam int CFG_SYNC_C = 15;
    localparam int CFG_SYNC_D = 14;
    localparam int CFG_SYNC_T = 13;
    localparam int CFG_WEATHER = 12;
    localparam int CFG_SELCALL = 11;
    localparam int CFG_RAW = 10;
    localparam int CFG_LAST = 9;
    localparam int CFG_USER = 2;
    localparam logic [15:0] CFG_RESET = 16'h0000;

    // Skip flags of the two characters in the transmit data word.
    localparam int TX_FLAG_HI = 15;
    localparam int TX_FLAG_LO = 7;
    localparam logic [15:0] TX_WORD_RESET = 16'h0000;

    // Tone status layout: index field and valid flag.
    localparam int TONE_IDX_HI = 14;
    localparam int TONE_IDX_LO = 11;
    localparam int TONE_VALID = 10;

    // Selector codes held in the top nibble of the audio-tone word.
    localparam logic [3:0] AUD_SEL_FREQ = 4'h0;
    localparam logic [3:0] AUD_SEL_LEVEL = 4'h2;
    localparam logic [3:0] AUD_SEL_RX_VOICE = 4'h4;
    localparam logic [3:0] AUD_SEL_OUT1 = 4'h6;
    localparam logic [3:0] AUD_SEL_OUT2 = 4'h8;
    localparam logic [3:0] AUD_SEL_TX_MULT = 4'hA;
    localparam logic [3:0] AUD_SEL_MOD_FINE = 4'hC;

    // Values after reset of the audio-tone fields; full scale is unity gain.
    localparam logic [11:0] AUD_FREQ_RESET = 12'h000;
    localparam logic [11:0] AUD_GAIN_RESET = 12'hFFF;
    localparam logic [11:0] AUD_ZERO_RESET = 12'h000;

    // Serial frame bit counts: eight address bits, then sixteen data bits.
    localparam logic [4:0] FRAME_ADDR_LAST = 5'h07;
    localparam logic [4:0] FRAME_REPLY_FIRST = 5'h08;
    localparam logic [4:0] FRAME_DATA_LAST = 5'h17;
    localparam logic [4:0] FRAME_DONE = 5'h18;

endpackage : dmhr_pkg

//--- rtl/dmhr_top.sv
// How it works
// - Tx final bit sent sets end flag.
// - Word needed or received sets ready flag.
// - Valid selective-call sequence sets its flag.
// - Program port free flag; cleared on write.
// - Status read clears bits two to fifteen.
// - Three independent sync pattern detect enables.
// - Weather enable skips sync, host clears it.
// - Selective-call mode plus modem enable runs modem.
// - Raw receive delivers sixteen-bit words.
// - Raw transmit sends words unformatted.
// - Last-block bit tells modulator to stop.
// - User bit carried through unchanged.
// - No new word: current word repeats.
// - Current word finishes before new one.
// - Formatted mode skips flagged characters.
// - Tone status reads identity after reset.
// - Tone index and valid; change sets event.
// - Transmit mode holds tone status zero.
// - Top nibble selects audio word meaning.
// - Tone enabled with zero frequency: bias only.
// - Tone frequency is one hertz per step.
// - Masked status change sets summary, drives pin.
`timescale 1ns/100ps

module dmhr_top #(
    parameter logic [15:0] ID_CODE = 16'h5A5A, // Identity code; value is arbitrary.
    parameter int SYNC_STAGES = 2 // Flip-flops in each toggle synchroniser.
) (
    // System clock and reset.
    input wire logic clk,
    input wire logic rst_n,
    // Serial control bus, clocked by its own serial clock.
    input wire logic link_sclk,
    input wire logic bus_select_n,
    input wire logic cmd_data,
    output logic reply_data,
    output logic reply_oe,
    // Mode levels from the mode control logic.
    input wire logic tx_mode,
    input wire logic modem_enable,
    input wire logic tone_enable,
    // Modem and detector events, one-cycle pulses on clk.
    input wire logic tx_last_bit_done,
    input wire logic tx_word_taken,
    input wire logic rx_word_ready,
    input wire logic selcall_seq_valid,
    input wire logic weather_change,
    input wire logic prog_word_taken,
    // Tone detector result.
    input wire logic [3:0] tone_index,
    input wire logic tone_valid_flag,
    // Interrupt mask word from the mask register.
    input wire dmhr_pkg::dmhr_word_t irq_mask,
    // Modem configuration outputs.
    output logic sync_pattern_c_enable,
    output logic sync_pattern_d_enable,
    output logic sync_pattern_t_enable,
    output logic sync_search_enable,
    output logic weather_data_enable,
    output logic selcall_mode_enable,
    output logic modem_run,
    output logic raw_mode,
    output logic last_block,
    output logic user_bit,
    // Program block port towards the program block store.
    output dmhr_pkg::dmhr_word_t program_word,
    output logic program_word_valid,
    // Transmit word towards the modulator.
    output dmhr_pkg::dmhr_word_t tx_word,
    output logic tx_skip_hi,
    output logic tx_skip_lo,
    // Audio tone and level settings.
    output logic [11:0] tone_freq_hz,
    output logic tone_on,
    output logic [11:0] tone_level,
    output logic [11:0] rx_voice_level,
    output logic [11:0] out1_gain,
    output logic [11:0] out2_gain,
    output logic [11:0] tx_voice_mult,
    output logic [11:0] mod_fine_atten,
    // Interrupt pin, active low.
    output logic interrupt_request_low
);
    import dmhr_pkg::*;

    // Refuse a synchroniser too short to settle a metastable sample.
    if (SYNC_STAGES < 2) begin : g_bad_sync
        $error("SYNC_STAGES must be at least two");
    end

    // Tells whether an address byte opens a read frame.
    function automatic logic is_readable(input logic [7:0] addr);
        is_readable = (addr == DMHR_ADDR_STATUS) || (addr == DMHR_ADDR_TONE_STATUS);
    endfunction : is_readable

    // ---------------- Serial clock domain ----------------

    // The frame logic restarts whenever the select line is high.
    wire frame_rst_n = rst_n & ~bus_select_n;

    logic [4:0] bit_cnt_q; // Bits taken in this frame.
    logic [22:0] shift_q; // Incoming address and data bits.
    logic rd_frame_q; // This frame reads a register.
    logic [7:0] rd_addr_q; // Address of the pending read; stable until next frame.
    logic [7:0] wr_addr_q; // Address of the last complete write.
    logic [15:0] wr_data_q; // Data of the last complete write.
    logic rd_tgl_q; // Toggles once per read request.
    logic wr_tgl_q; // Toggles once per complete write.
    wire [7:0] addr_now = {shift_q[6:0], cmd_data};
    wire addr_edge = (bit_cnt_q == FRAME_ADDR_LAST);
    wire data_edge = (bit_cnt_q == FRAME_DATA_LAST) && !rd_frame_q;

    // Counts and shifts bits of a frame on each rising serial clock edge.
    always_ff @(posedge link_sclk or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            bit_cnt_q <= 5'h00;
            shift_q <= 23'h000000;
            rd_frame_q <= 1'b0;
        end else begin
            if (bit_cnt_q != FRAME_DONE) begin
                bit_cnt_q <= bit_cnt_q + 5'h01;
            end
            shift_q <= {shift_q[21:0], cmd_data};
            if (addr_edge) begin
                rd_frame_q <= is_readable(addr_now);
            end
        end
    end

    // Publishes read and write requests; these survive the end of a frame.
    always_ff @(posedge link_sclk or negedge rst_n) begin
        if (!rst_n) begin
            rd_addr_q <= 8'h00;
            wr_addr_q <= 8'h00;
            wr_data_q <= 16'h0000;
            rd_tgl_q <= 1'b0;
            wr_tgl_q <= 1'b0;
        end else if (!bus_select_n) begin
            // An address byte naming a readable register asks for a snapshot.
            if (addr_edge && is_readable(addr_now)) begin
                rd_addr_q <= addr_now;
                rd_tgl_q <= ~rd_tgl_q;
            end
            // The last data bit completes a write; the words stay put until the next.
            if (data_edge) begin
                wr_addr_q <= shift_q[22:15];
                wr_data_q <= {shift_q[14:0], cmd_data};
                wr_tgl_q <= ~wr_tgl_q;
            end
        end
    end

    logic [15:0] rd_hold_q; // Snapshot word captured on clk.
    logic [14:0] reply_sh_q; // Remaining reply bits.

    // Drives reply bits on falling edges so the host samples them on rising ones.
    // The snapshot was captured on clk long before this half-period ends.
    always_ff @(negedge link_sclk or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            reply_data <= 1'b0;
            reply_oe <= 1'b0;
            reply_sh_q <= 15'h0000;
        end else if (rd_frame_q && bit_cnt_q == FRAME_REPLY_FIRST) begin
            reply_data <= rd_hold_q[15];
            reply_sh_q <= rd_hold_q[14:0];
            reply_oe <= 1'b1;
        end else begin
            reply_data <= reply_sh_q[14];
            reply_sh_q <= {reply_sh_q[13:0], 1'b0};
        end
    end

    // ---------------- System clock domain ----------------

    logic [SYNC_STAGES-1:0] rd_sync_q; // Read toggle synchroniser.
    logic [SYNC_STAGES-1:0] wr_sync_q; // Write toggle synchroniser.
    logic rd_seen_q; // Last read toggle acted upon.
    logic wr_seen_q; // Last write toggle acted upon.

    // Brings both request toggles onto clk; only the last stage is looked at.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_sync_q <= '0;
            wr_sync_q <= '0;
            rd_seen_q <= 1'b0;
            wr_seen_q <= 1'b0;
        end else begin
            rd_sync_q <= {rd_sync_q[SYNC_STAGES-2:0], rd_tgl_q};
            wr_sync_q <= {wr_sync_q[SYNC_STAGES-2:0], wr_tgl_q};
            rd_seen_q <= rd_sync_q[SYNC_STAGES-1];
            wr_seen_q <= wr_sync_q[SYNC_STAGES-1];
        end
    end

    // Request strobes and address decode on clk.
    wire rd_ev = rd_sync_q[SYNC_STAGES-1] ^ rd_seen_q;
    wire wr_ev = wr_sync_q[SYNC_STAGES-1] ^ wr_seen_q;
    wire rd_status = rd_ev && (rd_addr_q == DMHR_ADDR_STATUS);
    wire wr_cfg = wr_ev && (wr_addr_q == DMHR_ADDR_MODEM_CFG);
    wire wr_prog = wr_ev && (wr_addr_q == DMHR_ADDR_PROGRAM);
    wire wr_tx = wr_ev && (wr_addr_q == DMHR_ADDR_TX_DATA);
    wire wr_audio = wr_ev && (wr_addr_q == DMHR_ADDR_AUDIO);
    wire [3:0] aud_sel = wr_data_q[15:12];
    wire [11:0] aud_val = wr_data_q[11:0];

    logic [15:0] status_q; // Event status word.
    logic [15:0] cfg_q; // Modem configuration word.
    logic [15:0] tone_status_q; // Tone detector status word.
    logic [4:0] tone_prev_q; // Detector result seen last cycle.
    logic [15:0] tx_pend_q; // Word written by the host, not yet started.
    logic tx_pend_valid_q; // A pending word waits.

    // Tone detector change, seen only while receiving.
    wire [4:0] tone_now = {tone_index, tone_valid_flag};
    wire tone_chg = !tx_mode && (tone_now != tone_prev_q);

    // Hardware events that set status bits this cycle.
    wire [15:0] ev_raw = {1'b0, weather_change, 1'b0, tone_chg, 4'h0,
                          tx_mode && tx_last_bit_done,
                          tx_mode ? tx_word_taken : rx_word_ready,
                          2'b00, selcall_seq_valid, 3'b000};
    // Any unmasked event raises the summary bit too.
    wire irq_set = |(ev_raw & irq_mask & ~16'h8000);
    wire [15:0] ev = ev_raw | {irq_set, 15'h0000};
    // A read clears bits two and up; an event the same cycle still lands.
    wire [15:0] clr = rd_status ? ST_READ_CLEAR : 16'h0000;
    wire [15:0] status_upper = (status_q & ~clr) | ev;
    // The free flag is set when the stored word is taken and cleared by a write.
    wire prg_next = prog_word_taken | (status_q[ST_PRG] & ~wr_prog);

    // Status word update.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            status_q <= 16'h0001;
        end else begin
            status_q <= {status_upper[15:2], 1'b0, prg_next};
        end
    end

    // Snapshot for a serial read; the status read also clears, above.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_hold_q <= 16'h0000;
        end else if (rd_ev) begin
            rd_hold_q <= (rd_addr_q == DMHR_ADDR_STATUS) ? status_q : tone_status_q;
        end
    end

    // Tone status: identity after reset, detector result later, zero in transmit.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tone_status_q <= ID_CODE;
            tone_prev_q <= 5'h00;
        end else begin
            tone_prev_q <= tone_now;
            if (tx_mode) begin
                tone_status_q <= 16'h0000;
            end else if (tone_chg) begin
                tone_status_q <= {1'b0, tone_index, tone_valid_flag, 10'h000};
            end
        end
    end

    // Modem configuration word and the levels derived from it.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_q <= CFG_RESET;
            sync_search_enable <= 1'b0;
            modem_run <= 1'b0;
        end else begin
            if (wr_cfg) begin
                cfg_q <= wr_data_q;
            end
            // Weather data bypasses the sync search entirely.
            sync_search_enable <= (cfg_q[CFG_SYNC_C] | cfg_q[CFG_SYNC_D] |
                                   cfg_q[CFG_SYNC_T]) & ~cfg_q[CFG_WEATHER];
            modem_run <= cfg_q[CFG_SELCALL] & modem_enable;
        end
    end

    // Plain configuration bits go out straight from the word.
    assign sync_pattern_c_enable = cfg_q[CFG_SYNC_C];
    assign sync_pattern_d_enable = cfg_q[CFG_SYNC_D];
    assign sync_pattern_t_enable = cfg_q[CFG_SYNC_T];
    assign weather_data_enable = cfg_q[CFG_WEATHER];
    assign selcall_mode_enable = cfg_q[CFG_SELCALL];
    assign raw_mode = cfg_q[CFG_RAW];
    assign last_block = cfg_q[CFG_LAST];
    assign user_bit = cfg_q[CFG_USER];

    // Program block port: hold the word until the store takes it.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            program_word <= 16'h0000;
            program_word_valid <= 1'b0;
        end else if (wr_prog) begin
            program_word <= wr_data_q;
            program_word_valid <= 1'b1;
        end else if (prog_word_taken) begin
            program_word_valid <= 1'b0;
        end
    end

    // Transmit words: a host write waits until the current word is done.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_pend_q <= TX_WORD_RESET;
            tx_pend_valid_q <= 1'b0;
            tx_word <= TX_WORD_RESET;
        end else begin
            if (wr_tx) begin
                tx_pend_q <= wr_data_q;
            end
            // A new write keeps the pending flag set even as a word is taken.
            tx_pend_valid_q <= wr_tx | (tx_pend_valid_q & ~tx_word_taken);
            // The current word is replaced only at a word boundary, else repeated.
            if (tx_word_taken && tx_pend_valid_q) begin
                tx_word <= tx_pend_q;
            end
        end
    end

    // Character skip flags apply only in formatted mode; raw words go whole.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_skip_hi <= 1'b0;
            tx_skip_lo <= 1'b0;
        end else begin
            tx_skip_hi <= ~cfg_q[CFG_RAW] & tx_word[TX_FLAG_HI];
            tx_skip_lo <= ~cfg_q[CFG_RAW] & tx_word[TX_FLAG_LO];
        end
    end

    // Audio-tone word: the top nibble picks which setting the low bits load.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tone_freq_hz <= AUD_FREQ_RESET;
            tone_level <= AUD_GAIN_RESET;
            rx_voice_level <= AUD_GAIN_RESET;
            out1_gain <= AUD_GAIN_RESET;
            out2_gain <= AUD_GAIN_RESET;
            tx_voice_mult <= AUD_ZERO_RESET;
            mod_fine_atten <= AUD_ZERO_RESET;
        end else if (wr_audio) begin
            // Reserved selector codes are ignored.
            unique case (aud_sel)
                AUD_SEL_FREQ: tone_freq_hz <= aud_val;
                AUD_SEL_LEVEL: tone_level <= aud_val;
                AUD_SEL_RX_VOICE: rx_voice_level <= aud_val;
                AUD_SEL_OUT1: out1_gain <= aud_val;
                AUD_SEL_OUT2: out2_gain <= aud_val;
                AUD_SEL_TX_MULT: tx_voice_mult <= aud_val;
                AUD_SEL_MOD_FINE: mod_fine_atten <= aud_val;
                default: begin
                end
            endcase
        end
    end

    // Tone generator gate and interrupt pin.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tone_on <= 1'b0;
            interrupt_request_low <= 1'b1;
        end else begin
            // A zero frequency leaves the output at bias.
            tone_on <= tone_enable && (tone_freq_hz != 12'h000);
            interrupt_request_low <= ~(status_q[ST_IRQ] & irq_mask[ST_IRQ]);
        end
    end

    // ---------------- Checks on the system clock ----------------

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // A program write drops the free flag unless the port is freed again at once.
    property p_prg_cleared;
        wr_prog && !prog_word_taken |=> !status_q[ST_PRG] && program_word_valid;
    endproperty
    a_prg_cleared: assert property (p_prg_cleared) else $error("free flag not cleared");

    // A status read with no event leaves bits two and up at zero.
    property p_read_clears;
        rd_status && ev == 16'h0000 |=> status_q[15:2] == 14'h0000 && $stable(status_q[0]);
    endproperty
    a_read_clears: assert property (p_read_clears) else $error("read did not clear");

    // An end-of-data event in the clearing cycle survives.
    property p_set_wins;
        rd_status && tx_mode && tx_last_bit_done |=> status_q[ST_END];
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("event lost on read");

    // In receive mode the end flag is never raised.
    property p_end_rx_quiet;
        !tx_mode && !status_q[ST_END] |=> !status_q[ST_END];
    endproperty
    a_end_rx_quiet: assert property (p_end_rx_quiet) else $error("end flag in receive");

    // A word taken in transmit mode asks for the next one.
    property p_ready_tx;
        tx_mode && tx_word_taken |=> status_q[ST_RDY];
    endproperty
    a_ready_tx: assert property (p_ready_tx) else $error("ready flag missing");

    // The tone word stays zero while transmitting.
    property p_tone_zero_tx;
        tx_mode [*2] |-> tone_status_q == 16'h0000;
    endproperty
    a_tone_zero_tx: assert property (p_tone_zero_tx) else $error("tone word not zero");

    // With nothing pending the current word is repeated.
    property p_repeat_word;
        tx_word_taken && !tx_pend_valid_q |=> $stable(tx_word);
    endproperty
    a_repeat_word: assert property (p_repeat_word) else $error("word not repeated");

    // A host write never changes the word mid-transmission.
    property p_no_truncate;
        !tx_word_taken |=> $stable(tx_word);
    endproperty
    a_no_truncate: assert property (p_no_truncate) else $error("word cut short");

    // A detector change in receive mode raises the tone event one cycle later.
    property p_tone_event;
        tone_chg |=> status_q[ST_TONE];
    endproperty
    a_tone_event: assert property (p_tone_event) else $error("tone event missing");

    // The pin follows the summary bit and the master mask one cycle later.
    property p_irq_pin;
        status_q[ST_IRQ] && irq_mask[ST_IRQ] |=> !interrupt_request_low;
    endproperty
    a_irq_pin: assert property (p_irq_pin) else $error("interrupt pin idle");

    // The modem runs two cycles after a mode write, with the enable held.
    property p_modem_run;
        wr_cfg && wr_data_q[CFG_SELCALL] ##1 modem_enable |=> modem_run;
    endproperty
    a_modem_run: assert property (p_modem_run) else $error("modem not started");

    // Main scenarios worth seeing.
    property p_cov_status_read;
        rd_status ##1 (status_q[15:2] == 14'h0000);
    endproperty
    c_status_read: cover property (p_cov_status_read);

    property p_cov_word_swap;
        wr_tx ##[1:300] (tx_word_taken && tx_pend_valid_q);
    endproperty
    c_word_swap: cover property (p_cov_word_swap);

    property p_cov_tone;
        tone_chg ##1 status_q[ST_TONE];
    endproperty
    c_tone: cover property (p_cov_tone);

endmodule : dmhr_top

//--- verif/dmhr_host.sv
`timescale 1ns/100ps
// Host model; its serial clock stands still between frames.
module dmhr_host (
    // Serial bus lines.
    output logic link_sclk,
    output logic bus_select_n,
    output logic cmd_data,
    input wire logic reply_data,
    input wire logic reply_oe
);
    initial begin
        link_sclk = 1'b0;
        bus_select_n = 1'b1;
        cmd_data = 1'b0;
    end
    // One whole frame, MSB first; reply bits are taken on rising edges.
    task automatic xfer(input logic [7:0] a, input logic [15:0] d, output logic [15:0] r);
        logic [23:0] sh;
        sh = {a, d};
        r = 16'h0000;
        #1.3 bus_select_n = 1'b0;
        for (int i = 23; i >= 0; i--) begin
            cmd_data = sh[i];
            #62.5 link_sclk = 1'b1;
            // The model never powers the device down, so every reply is valid.
            if (i < 16 && reply_oe) r[i] = reply_data;
            #62.5 link_sclk = 1'b0;
        end
        // A released line must not keep showing its last bit.
        cmd_data = ~cmd_data;
        #62.5 bus_select_n = 1'b1;
        #250;
    endtask : xfer
endmodule : dmhr_host

//--- verif/tb.sv
`timescale 1ns/100ps
module tb;
    import dmhr_pkg::*;
    localparam logic [15:0] ID = 16'h3C3C; // Identity value is arbitrary.
    logic clk, rst_n, tx_mode, modem_enable, tone_enable, tone_valid_flag, tone_on;
    logic tx_last_bit_done, tx_word_taken, rx_word_ready, selcall_seq_valid;
    logic weather_change, prog_word_taken, interrupt_request_low, program_word_valid;
    logic link_sclk, bus_select_n, cmd_data, reply_data, reply_oe, tx_skip_hi, tx_skip_lo;
    logic sync_pattern_c_enable, sync_pattern_d_enable, sync_pattern_t_enable;
    logic sync_search_enable, weather_data_enable, selcall_mode_enable, modem_run;
    logic raw_mode, last_block, user_bit;
    logic [5:0] ev;
    logic [3:0] tone_index;
    logic [11:0] tone_freq_hz, tone_level, rx_voice_level, out1_gain, out2_gain;
    logic [11:0] tx_voice_mult, mod_fine_atten;
    logic [83:0] audv;
    dmhr_word_t irq_mask, rd, program_word, tx_word, cfgv;
    int fails = 0;
    int check_count = 0;
    int cyc = 0;
    assign {tx_last_bit_done, tx_word_taken, rx_word_ready} = ev[5:3];
    assign {selcall_seq_valid, weather_change, prog_word_taken} = ev[2:0];
    assign cfgv = {6'h00, sync_pattern_c_enable, sync_pattern_d_enable, sync_pattern_t_enable,
        weather_data_enable, selcall_mode_enable, raw_mode, last_block, user_bit,
        sync_search_enable, modem_run};
    assign audv = {tone_freq_hz, tone_level, rx_voice_level, out1_gain, out2_gain,
        tx_voice_mult, mod_fine_atten};
    dmhr_top #(.ID_CODE(ID)) dmhr_top_i (.*);
    dmhr_host dmhr_host_i (.*);
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // Prints the verdict and ends the run.
    task finish_test;
        if (fails == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : finish_test
    task chk(input dmhr_word_t g, input dmhr_word_t e);
        check_count++;
        if (g !== e) begin
            fails++;
            $display("MISMATCH %0t got %h expected %h", $time, g, e);
        end
    endtask : chk
    // One-cycle event pulse on bit b of the event vector.
    task pulse(input int b);
        @(posedge clk) ev <= 6'h01 << b;
        @(posedge clk) ev <= 6'h00;
        repeat (3) @(posedge clk);
    endtask : pulse
    task wr(input logic [7:0] a, input dmhr_word_t d);
        dmhr_host_i.xfer(a, d, rd);
    endtask : wr
    task rdchk(input logic [7:0] a, input dmhr_word_t e);
        dmhr_host_i.xfer(a, 16'h0000, rd);
        chk(rd, e);
    endtask : rdchk
    // Hang guard.
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            fails++;
            finish_test();
        end
    end
    initial begin
        {rst_n, ev, tx_mode, modem_enable, tone_enable, tone_index, tone_valid_flag} = '0;
        irq_mask = 16'h0000;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        rdchk(DMHR_ADDR_TONE_STATUS, ID);
        rdchk(DMHR_ADDR_STATUS, 16'h0001);
        wr(DMHR_ADDR_PROGRAM, 16'h1234);
        chk(program_word, 16'h1234);
        chk({15'h0000, program_word_valid}, 16'h0001);
        rdchk(DMHR_ADDR_STATUS, 16'h0000);
        pulse(0);
        chk({15'h0000, program_word_valid}, 16'h0000);
        rdchk(DMHR_ADDR_STATUS, 16'h0001);
        @(posedge clk) {tx_mode, modem_enable, tone_enable, irq_mask} <= {3'b111, 16'h80C0};
        pulse(5);
        pulse(4);
        chk({15'h0000, interrupt_request_low}, 16'h0000);
        rdchk(DMHR_ADDR_STATUS, 16'h80C1);
        rdchk(DMHR_ADDR_STATUS, 16'h0001);
        chk({15'h0000, interrupt_request_low}, 16'h0001);
        fork
            rdchk(DMHR_ADDR_STATUS, 16'h0001);
            begin repeat (500) @(posedge clk); pulse(2); end
        join
        rdchk(DMHR_ADDR_STATUS, 16'h0009);
        // End-of-data held across a clearing read must survive it.
        @(posedge clk) ev <= 6'h20;
        rdchk(DMHR_ADDR_STATUS, 16'h8081);
        @(posedge clk) ev <= 6'h00;
        rdchk(DMHR_ADDR_STATUS, 16'h8081);
        wr(DMHR_ADDR_MODEM_CFG, 16'hE404);
        chk(cfgv, 16'h0396);
        wr(DMHR_ADDR_MODEM_CFG, 16'h1A00);
        chk(cfgv, 16'h0069);
        wr(8'hC9, 16'hFFFF);
        chk(cfgv, 16'h0069);
        wr(DMHR_ADDR_TX_DATA, 16'h8012);
        pulse(4);
        chk(tx_word, 16'h8012);
        chk({14'h0000, tx_skip_hi, tx_skip_lo}, 16'h0002);
        wr(DMHR_ADDR_TX_DATA, 16'h0080);
        chk(tx_word, 16'h8012);
        pulse(4);
        chk({14'h0000, tx_skip_hi, tx_skip_lo}, 16'h0001);
        pulse(4);
        chk(tx_word, 16'h0080);
        rdchk(DMHR_ADDR_TONE_STATUS, 16'h0000);
        @(posedge clk) {tx_mode, tone_index, tone_valid_flag} <= {1'b0, 4'h5, 1'b1};
        repeat (4) @(posedge clk);
        dmhr_host_i.xfer(DMHR_ADDR_TONE_STATUS, 16'h0000, rd);
        chk(rd & 16'h7C00, 16'h2C00);
        dmhr_host_i.xfer(DMHR_ADDR_STATUS, 16'h0000, rd);
        chk(rd & 16'h1000, 16'h1000);
        for (int i = 0; i < 7; i++) wr(DMHR_ADDR_AUDIO, {i[2:0], 1'b0, 8'h10, i[3:0]});
        for (int i = 0; i < 7; i++) chk({4'h0, audv[(6 - i) * 12 +: 12]}, {8'h01, 4'h0, i[3:0]});
        chk({15'h0000, tone_on}, 16'h0001);
        wr(DMHR_ADDR_AUDIO, 16'h0000);
        chk({15'h0000, tone_on}, 16'h0000);
        finish_test();
    end
endmodule : tb
